//--- rtl/osdra_params.svh
// constants of the display ram access and enable block
`ifndef OSDRA_PARAMS_SVH
`define OSDRA_PARAMS_SVH
// core data-space addresses
`define OSDRA_PAGE_REG     8'hE8
`define OSDRA_SYNC_STAT    8'hE4
`define OSDRA_BANK_REG     8'hED
`define OSDRA_PAGE_SPAN    8'h40
`define OSDRA_VSTART_ADDR  8'h10
`define OSDRA_HSTART_ADDR  8'h11
`define OSDRA_VSPACE_ADDR  8'h12
`define OSDRA_HSPACE_ADDR  8'h13
`define OSDRA_BGCTL_ADDR   8'h14
`define OSDRA_GEN_ADDR     8'h17
`define OSDRA_PAGE5_BIT    5
`define OSDRA_PAGE6_BIT    6
`define OSDRA_VS_STAT_BIT  4
// ram geometry
`define OSDRA_RAM_WORDS    80
`define OSDRA_ROWS         3'h5
`define OSDRA_ROW5_BASE    7'h40
`define OSDRA_LAST_COL     5'h0F
`define OSDRA_BAR_COL      5'h10
`define OSDRA_IDLE_COL     5'h11
// character code fields
`define OSDRA_CH_SPACE     6
`define OSDRA_FMT_SIZE     6
`define OSDRA_CH_HSE       5
`define OSDRA_FMT_VSE      5
`define OSDRA_CH_WE        4
`define OSDRA_CH_BGS       3
`define OSDRA_REG_FLAG     6
`define OSDRA_GLYPH_MSB    5
// timing
`define OSDRA_CLK_NS       4
`define OSDRA_TDOT_NS      400
`define OSDRA_DOT_DIV      7'((`OSDRA_TDOT_NS) / (`OSDRA_CLK_NS))
`define OSDRA_HS_BASE      7'h0A
`define OSDRA_CELL_TDOTS   7'h06
`define OSDRA_ROW_LINES    9'h012
`define OSDRA_FLYBACK_LINES 5'h19
`endif

//--- rtl/osdra_pkg.sv
// types of the display ram access and enable block
`include "osdra_params.svh"
package osdra_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } osdra_bus_req_type;

    typedef struct packed {
        logic       red;
        logic       green;
        logic       blue;
        logic       blank;
    } osdra_video_type;

    typedef struct packed {
        logic       bank;
        logic [5:0] code;
        logic [3:0] grow;
    } osdra_glyph_req_type;

    typedef struct packed {
        logic [`OSDRA_RAM_WORDS-1:0][6:0] ram;
        logic [7:0]          page;
        logic                ge;
        logic                bank;
        logic [7:0]          vstart;
        logic [7:0]          hstart;
        logic [7:0]          vspace;
        logic [7:0]          hspace;
        logic [7:0]          bgctl;
        logic [7:0]          rdata;
        logic                osc_run;
        logic                vs_d;
        logic                hs_d;
        logic [4:0]          fly;
        logic [6:0]          div;
        logic [8:0]          vline;
        logic [2:0]          row;
        logic [8:0]          rline;
        logic                vact;
        logic [6:0]          hcnt;
        logic [4:0]          col;
        logic [6:0]          cdot;
        logic [6:0]          attr;
        logic                last_space;
        osdra_glyph_req_type glyph;
        osdra_video_type     video;
    } osdra_state_type;
endpackage

//--- rtl/osdra_core.sv
// display ram, core write port, oscillator gating and character output timing
// Operation
// - ram holds five lines of sixteen columns; column 0 hidden format character
// - column 0 of each line is a format character, never drawn as a glyph
// - core sees 80 ram words plus 6 control registers over two pages
// - page register value with bit 5 maps first four rows at offsets 0..3F
// - page register bit 6 maps fifth row 0..0F and registers 10..14, 17
// - ram is dual ported, shared by core writes and the display engine
// - core access to all 86 display locations is write only
// - first 85 locations writable only while oscillator stopped; enable always writable
// - enable bit set means display on, cleared means display off
// - oscillator starts at next vertical sync after enable is set, or at once if set inside the flyback window
// - clearing enable stops the oscillator at once
// - enable set after flyback end waits for the following frame
// - bit 4 of status address E4 reads inverted vertical sync pin
// - display timing locks to horizontal and vertical sync inputs
// - four outputs drive external video: red, green, blue, blank
// - space at line end with size 0 format yields background bar
// - with enable set each word shown per its word enable bit
// - format character sets size, vertical space enable and first word attributes
// - each ram word holds a seven bit character or attribute code
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "osdra_params.svh"

module osdra_core
    import osdra_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    input  osdra_bus_req_type  core_req,
    output logic [7:0]         core_rdata,
    input  wire logic          vsync,
    input  wire logic          hsync,
    output osdra_glyph_req_type glyph_req,
    input  wire logic [5:0]    glyph_bits,
    output osdra_video_type    video
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and the whole block state
    logic            rst_meta_ff;
    logic            rst_sync_ff;
    osdra_state_type st_ff;
    osdra_state_type nxt_st;

    // sync edges and core window decode
    logic       vs_rise;
    logic       hs_rise;
    logic       pg5;
    logic       pg6;
    logic       in_win;
    logic [6:0] wr_idx;

    // current row and character fetch
    logic [6:0] row_base;
    logic [6:0] fmt;
    logic [6:0] chr;
    logic [6:0] next_chr;
    logic       size;
    logic [8:0] row_h;
    logic [8:0] gap;
    logic       tdot;
    logic       is_space;
    logic [6:0] cell_w;
    logic [4:0] col_inc;

    // pixel and background path
    logic [2:0] gsel;
    logic [5:0] gb_sh;
    logic       pix;
    logic       bg_sel;
    logic       bg_on;
    logic [5:0] bg_rgb;
    logic       in_text;
    logic       shown;
    logic       bar;

    ////////////////////////////////////////////////////////////////////////////
    // release is synchronised so no state flop sees reset leave near an edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = 8'h00;
        nxt_st.vs_d  = vsync;
        nxt_st.hs_d  = hsync;
        vs_rise      = vsync & ~st_ff.vs_d;
        hs_rise      = hsync & ~st_ff.hs_d;

        // page 5 wins if software sets both page bits
        pg5    = st_ff.page[`OSDRA_PAGE5_BIT];
        pg6    = st_ff.page[`OSDRA_PAGE6_BIT] & ~pg5;
        in_win = core_req.addr < `OSDRA_PAGE_SPAN;
        // page 6 maps offsets 00..0f onto the fifth row
        wr_idx = pg5 ? {1'b0, core_req.addr[5:0]}
                     : (`OSDRA_ROW5_BASE | {3'b000, core_req.addr[3:0]});

        // core write port
        // a refused write is dropped silently; the core sees no error
        if (core_req.wr) begin
            if (core_req.addr == `OSDRA_PAGE_REG) begin
                nxt_st.page = core_req.wdata;
            end else if (core_req.addr == `OSDRA_BANK_REG) begin
                // locked while enabled so the glyph set never changes mid-field
                if (!st_ff.ge) begin
                    nxt_st.bank = core_req.wdata[0];
                end
            end else if (in_win && pg6 && core_req.addr == `OSDRA_GEN_ADDR) begin
                nxt_st.ge = core_req.wdata[0];
            end else if (in_win && (pg5 || pg6) && !st_ff.osc_run) begin
                if (pg5 || core_req.addr < `OSDRA_VSTART_ADDR) begin
                    // only seven bits are stored; bit 7 of the byte is dropped
                    nxt_st.ram[wr_idx] = core_req.wdata[6:0];
                end else begin
                    // offsets 15, 16 and 18..3f of page 6 are unmapped
                    case (core_req.addr)
                        `OSDRA_VSTART_ADDR: nxt_st.vstart = core_req.wdata;
                        `OSDRA_HSTART_ADDR: nxt_st.hstart = core_req.wdata;
                        `OSDRA_VSPACE_ADDR: nxt_st.vspace = core_req.wdata;
                        `OSDRA_HSPACE_ADDR: nxt_st.hspace = core_req.wdata;
                        `OSDRA_BGCTL_ADDR:  nxt_st.bgctl  = core_req.wdata;
                        default: ;
                    endcase
                end
            end
        end

        // read port: display locations have no read path
        // read data clears itself every cycle so a stale byte never lingers
        if (core_req.rd) begin
            case (core_req.addr)
                `OSDRA_SYNC_STAT: nxt_st.rdata[`OSDRA_VS_STAT_BIT] = ~vsync;
                `OSDRA_PAGE_REG:  nxt_st.rdata = st_ff.page;
                default:          nxt_st.rdata = 8'h00;
            endcase
        end

        // flyback window counted in lines after the sync edge
        // nonzero for the whole window so a prompt enable still starts this field
        if (vs_rise) begin
            nxt_st.fly = `OSDRA_FLYBACK_LINES;
        end else if (hs_rise && st_ff.fly != 5'h00) begin
            nxt_st.fly = st_ff.fly - 5'h01;
        end

        // oscillator gate: a late enable misses this field and waits a frame
        // clearing wins over starting, so a cleared enable always leaves it off
        if (!nxt_st.ge) begin
            nxt_st.osc_run = 1'b0;
        end else if (st_ff.ge && (vs_rise || st_ff.fly != 5'h00)) begin
            nxt_st.osc_run = 1'b1;
        end

        // dot divider, realigned on every line sync
        // a free-running divider would let the text drift against the picture
        tdot = st_ff.osc_run && st_ff.div == `OSDRA_DOT_DIV - 7'h01;
        if (!st_ff.osc_run || hs_rise || tdot) begin
            nxt_st.div = 7'h00;
        end else begin
            nxt_st.div = st_ff.div + 7'h01;
        end

        // current row and its format character
        row_base = {st_ff.row, 4'h0};
        fmt      = (st_ff.row < `OSDRA_ROWS) ? st_ff.ram[row_base] : 7'h00;
        size     = fmt[`OSDRA_FMT_SIZE];
        row_h    = `OSDRA_ROW_LINES << size;
        gap      = fmt[`OSDRA_FMT_VSE] ? {1'b0, st_ff.vspace[5:0], 2'b00} : 9'h000;
        chr      = (st_ff.row < `OSDRA_ROWS && st_ff.col <= `OSDRA_LAST_COL)
                   ? st_ff.ram[row_base | {3'b000, st_ff.col[3:0]}] : 7'h00;
        col_inc  = st_ff.col + 5'h01;
        next_chr = (st_ff.row < `OSDRA_ROWS && col_inc <= `OSDRA_LAST_COL)
                   ? st_ff.ram[row_base | {3'b000, col_inc[3:0]}] : 7'h00;
        is_space = chr[`OSDRA_CH_SPACE];
        // a space with horizontal space enable widens its cell
        cell_w   = (`OSDRA_CELL_TDOTS << size)
                   + ((is_space && st_ff.attr[`OSDRA_CH_HSE])
                      ? ({1'b0, st_ff.hspace[5:0]} + 7'h01) << size : 7'h00);
        // bar only in size 0 lines, matching the end-of-line artefact
        bar      = st_ff.last_space && !size;

        // vertical: line count from sync, rows stacked from the start line
        // rows past the fifth stay dark until the next vertical sync
        if (vs_rise) begin
            nxt_st.vline = 9'h000;
            nxt_st.row   = 3'h0;
            nxt_st.rline = 9'h000;
            nxt_st.vact  = 1'b0;
        end else if (hs_rise && st_ff.osc_run) begin
            nxt_st.vline = st_ff.vline + 9'h001;
            if (!st_ff.vact) begin
                if (st_ff.row < `OSDRA_ROWS &&
                    st_ff.vline + 9'h001 == {1'b0, st_ff.vstart[5:0], 2'b00}) begin
                    nxt_st.vact  = 1'b1;
                    nxt_st.rline = 9'h000;
                end
            end else if (st_ff.rline + 9'h001 == row_h + gap) begin
                nxt_st.row   = st_ff.row + 3'h1;
                nxt_st.rline = 9'h000;
                nxt_st.vact  = st_ff.row + 3'h1 < `OSDRA_ROWS;
            end else begin
                nxt_st.rline = st_ff.rline + 9'h001;
            end
        end

        // horizontal: start delay, then columns 1..15 and an optional bar cell
        // column 16 is the bar cell, column 17 parks the line until the next sync
        if (hs_rise) begin
            nxt_st.hcnt       = 7'h00;
            nxt_st.col        = 5'h00;
            nxt_st.cdot       = 7'h00;
            nxt_st.attr       = fmt;
            nxt_st.last_space = 1'b0;
        end else if (tdot && st_ff.vact) begin
            // column 0 counts the start delay, covering the ram and glyph fetch
            if (st_ff.col == 5'h00) begin
                nxt_st.hcnt = st_ff.hcnt + 7'h01;
                if (st_ff.hcnt + 7'h01 == `OSDRA_HS_BASE + {1'b0, st_ff.hstart[5:0]}) begin
                    nxt_st.col = 5'h01;
                    if (next_chr[`OSDRA_CH_SPACE]) begin
                        nxt_st.attr = next_chr;
                    end
                end
            end else if (st_ff.col <= `OSDRA_BAR_COL) begin
                if (st_ff.cdot + 7'h01 >= cell_w) begin
                    nxt_st.cdot = 7'h00;
                    if (st_ff.col == `OSDRA_LAST_COL) begin
                        nxt_st.last_space = is_space;
                        nxt_st.col = (is_space && !size) ? `OSDRA_BAR_COL : `OSDRA_IDLE_COL;
                    end else begin
                        nxt_st.col = col_inc;
                        if (col_inc <= `OSDRA_LAST_COL && next_chr[`OSDRA_CH_SPACE]) begin
                            nxt_st.attr = next_chr;
                        end
                    end
                end else begin
                    nxt_st.cdot = st_ff.cdot + 7'h01;
                end
            end
        end

        // glyph fetch; the external rom answers well inside one dot period
        // its bits feed the pixel path combinationally
        nxt_st.glyph.bank = st_ff.bank;
        nxt_st.glyph.code = chr[5:0];
        // size 1 doubles every glyph row
        nxt_st.glyph.grow = size ? st_ff.rline[5:2] : st_ff.rline[4:1];

        // pixel and background
        // attr follows the last space or format character seen on the line
        // text rows end before the vertical space gap
        in_text = st_ff.vact && st_ff.rline < row_h;
        shown   = st_ff.osc_run && in_text && st_ff.col != 5'h00
                  && st_ff.col <= `OSDRA_BAR_COL && st_ff.attr[`OSDRA_CH_WE];
        // size 1 doubles every dot
        gsel    = size ? st_ff.cdot[3:1] : st_ff.cdot[2:0];
        gb_sh   = glyph_bits << gsel;
        pix     = shown && st_ff.col <= `OSDRA_LAST_COL && !is_space && gb_sh[`OSDRA_GLYPH_MSB];
        bg_sel  = st_ff.attr[`OSDRA_CH_BGS];
        // the background register holds both colours bit-interleaved
        bg_rgb  = bg_sel ? {st_ff.bgctl[5], st_ff.bgctl[3], st_ff.bgctl[1], 3'b000}
                         : {st_ff.bgctl[4], st_ff.bgctl[2], st_ff.bgctl[0], 3'b000};
        // space blanking does not apply to the bar, which is a hardware artefact
        bg_on   = shown && st_ff.bgctl[6 + {31'h0, bg_sel}]
                  && (st_ff.col == `OSDRA_BAR_COL ? bar
                      : (!is_space || !st_ff.hstart[`OSDRA_REG_FLAG]));

        // four video outputs, screen blank forced regardless of enable
        nxt_st.video.red   = pix ? st_ff.attr[2] : (bg_on & bg_rgb[5]);
        nxt_st.video.green = pix ? st_ff.attr[1] : (bg_on & bg_rgb[4]);
        nxt_st.video.blue  = pix ? st_ff.attr[0] : (bg_on & bg_rgb[3]);
        nxt_st.video.blank = st_ff.vspace[`OSDRA_REG_FLAG] | pix | bg_on;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one register for all state; ram words reset to zero with the rest
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output comes straight from a flop
    assign core_rdata = st_ff.rdata;
    assign glyph_req  = st_ff.glyph;
    assign video      = st_ff.video;

endmodule // osdra_core

//--- tb/osdra_core_properties.sv
// port checks of the display ram access and enable block
module osdra_core_properties
    import osdra_pkg::*;
(
    input wire logic           sys_clk,
    input wire logic           resetn,
    input osdra_bus_req_type   core_req,
    input wire logic [7:0]     core_rdata,
    input wire logic           vsync,
    input wire logic           hsync,
    input osdra_glyph_req_type glyph_req,
    input wire logic [5:0]     glyph_bits,
    input osdra_video_type     video
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] page_ff;
    logic       ge_ff;
    logic       bank_ff;
    logic       vs_seen_ff;
    logic       ge_wr;
    logic [2:0] colour;
    // enable sits behind page 6 only; bit 5 wins when both are set
    assign ge_wr  = core_req.wr && core_req.addr == 8'h17 && page_ff[6] && !page_ff[5];
    assign colour = {video.red, video.green, video.blue};
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            page_ff    <= 8'h00;
            ge_ff      <= 1'b0;
            bank_ff    <= 1'b0;
            vs_seen_ff <= 1'b0;
        end else begin
            if (core_req.wr && core_req.addr == 8'hE8) page_ff <= core_req.wdata;
            if (ge_wr) ge_ff <= core_req.wdata[0];
            if (core_req.wr && core_req.addr == 8'hED && !ge_ff) bank_ff <= core_req.wdata[0];
            if (vsync) vs_seen_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    rd_idle_zero_a: assert property (!core_req.rd |=> core_rdata == 8'h00)
        else $error("read data not zero outside a read");
    sync_status_a: assert property (core_req.rd && core_req.addr == 8'hE4
        |=> core_rdata == {3'h0, ~$past(vsync), 4'h0}) else $error("sync status bit wrong");
    write_only_a: assert property (core_req.rd && core_req.addr != 8'hE4 && core_req.addr != 8'hE8
        |=> core_rdata == 8'h00) else $error("display location read not zero");
    page_readback_a: assert property (core_req.rd && core_req.addr == 8'hE8
        |=> core_rdata == $past(page_ff)) else $error("page register readback wrong");
    ge_clear_stop_a: assert property (ge_wr && !core_req.wdata[0]
        |-> ##3 (colour == 3'h0) [*2]) else $error("video still active after enable cleared");
    ge_off_dark_a: assert property (!ge_ff && !$past(ge_ff) && !$past(ge_ff, 2)
        |-> colour == 3'h0) else $error("video active with enable clear");
    bank_follow_a: assert property ($changed(glyph_req.bank)
        |-> glyph_req.bank == bank_ff) else $error("glyph bank took a refused write");
    sync_start_a: assert property (!vs_seen_ff |-> colour == 3'h0)
        else $error("display started before any vertical sync");
endmodule // osdra_core_properties

//--- tb/osdra_sync_src.sv
// sync source and glyph rom standing in for the video side
module osdra_sync_src
    import osdra_pkg::*;
#(
    parameter int HPERIOD = 2000
)
(
    input wire logic           sys_clk,
    input wire logic           vs_req,
    input osdra_glyph_req_type glyph_req,
    output logic               hsync,
    output logic               vsync,
    output logic [5:0]         glyph_bits
);
    timeunit 1ns;
    timeprecision 100ps;
    int hcnt = 0;
    int vcnt = 0;
    initial begin
        hsync = 1'b0;
        vsync = 1'b0;
    end
    // line sync runs free; the display must lock onto it
    always @(posedge sys_clk) begin
        hcnt  <= (hcnt == HPERIOD - 1) ? 0 : hcnt + 1;
        hsync <= hcnt < 8;
        vcnt  <= vs_req ? 40 : (vcnt > 0 ? vcnt - 1 : 0);
        vsync <= vcnt > 0;
    end
    // rows differ per code and row so a stale fetch shows up
    assign glyph_bits = glyph_req.code ^ {2'h0, glyph_req.grow};
endmodule // osdra_sync_src

//--- tb/test_osd_ram_access_and_enable.sv
// self-checking bench of the display ram access and enable block
module test_osd_ram_access_and_enable import osdra_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic                sys_clk    = 1'b0;
    logic                resetn     = 1'b0;
    logic                vs_req     = 1'b0;
    osdra_bus_req_type   core_req   = '0;
    logic [7:0]          core_rdata;
    logic                vsync;
    logic                hsync;
    osdra_glyph_req_type glyph_req;
    logic [5:0]          glyph_bits;
    osdra_video_type     video;
    logic [7:0]          v;
    int                  err_total   = 0;
    int                  comparisons = 0;
    always #2 sys_clk = ~sys_clk;
    osdra_core osdra_core_inst (.sys_clk(sys_clk), .resetn(resetn), .core_req(core_req),
        .core_rdata(core_rdata), .vsync(vsync), .hsync(hsync), .glyph_req(glyph_req),
        .glyph_bits(glyph_bits), .video(video));
    osdra_sync_src osdra_sync_src_inst (.sys_clk(sys_clk), .vs_req(vs_req), .glyph_req(glyph_req),
        .hsync(hsync), .vsync(vsync), .glyph_bits(glyph_bits));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        core_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        core_req.wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        core_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        core_req.rd <= 1'b0;
        #1 d = core_rdata;
    endtask
    task automatic pulse_vsync();
        @(posedge sys_clk);
        vs_req <= 1'b1;
        @(posedge sys_clk);
        vs_req <= 1'b0;
    endtask
    // bounded hunt for a glyph fetch of one code
    task automatic wait_code(input logic [5:0] c, input int bound);
        int n;
        n = 0;
        while (glyph_req.code !== c && n < bound) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == bound) begin
            err_total++;
            $display("BAD glyph code expected %h seen %h", c, glyph_req.code);
            stop_test();
        end
    endtask
    // bounded hunt for a white lit dot with blanking
    task automatic wait_lit(input int bound);
        int n;
        n = 0;
        while (video !== 4'hF && n < bound) begin
            @(posedge sys_clk);
            n++;
        end
        check("video lit", 8'h0F, {4'h0, video});
    endtask
    task automatic dark(input int cycles);
        int   n;
        logic bad;
        bad = 1'b0;
        for (n = 0; n < cycles; n++) begin
            @(posedge sys_clk);
            #1 if (video !== 4'h0) bad = 1'b1;
        end
        check("video dark", 8'h00, {7'h0, bad});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus_wr(8'hE8, 8'h20);
        bus_rd(8'hE8, v);
        check("page register", 8'h20, v);
        bus_wr(8'h00, 8'h17);
        bus_wr(8'h01, 8'h2A);
        bus_rd(8'h01, v);
        check("ram read", 8'h00, v);
        bus_wr(8'hE8, 8'h40);
        // text starts four lines after vertical sync
        bus_wr(8'h10, 8'h01);
        bus_wr(8'h14, 8'h00);
        bus_rd(8'hE4, v);
        check("sync status low", 8'h10, v);
        bus_wr(8'h17, 8'h01);
        bus_rd(8'h17, v);
        check("enable read", 8'h00, v);
        // enable alone must not start anything until a vertical sync
        dark(6000);
        $display("test start held done");
        pulse_vsync();
        bus_rd(8'hE4, v);
        check("sync status high", 8'h00, v);
        wait_code(6'h2A, 30000);
        wait_lit(200);
        bus_wr(8'hED, 8'h01);
        bus_wr(8'hE8, 8'h20);
        bus_wr(8'h01, 8'h15);
        wait_code(6'h00, 4000);
        wait_code(6'h2A, 4000);
        check("bank locked", 8'h00, {7'h0, glyph_req.bank});
        bus_wr(8'hE8, 8'h40);
        bus_wr(8'h17, 8'h00);
        dark(4000);
        $display("test locked writes done");
        bus_wr(8'hED, 8'h01);
        bus_wr(8'hE8, 8'h20);
        bus_wr(8'h01, 8'h15);
        bus_wr(8'hE8, 8'h40);
        // page 6 offset 1 belongs to row five, not row one
        bus_wr(8'h01, 8'h33);
        bus_wr(8'h17, 8'h01);
        pulse_vsync();
        wait_code(6'h15, 30000);
        check("bank taken", 8'h01, {7'h0, glyph_req.bank});
        $display("test unlocked writes done");
        stop_test();
    end
endmodule // test_osd_ram_access_and_enable

bind osdra_core osdra_core_properties osdra_core_properties_inst (.sys_clk(sys_clk), .resetn(resetn),
    .core_req(core_req), .core_rdata(core_rdata), .vsync(vsync), .hsync(hsync),
    .glyph_req(glyph_req), .glyph_bits(glyph_bits), .video(video));
